// [logic/ipst_cfg.svh]
// Constants for the timer priority group and software trigger block.
// Assumes a 100 MHz core clock and a plain address/strobe register port.
// Contract
// - First timer priority at bits 7:5
// - Second timer priority at bits 15:13
// - Eight levels, level zero wins arbitration
// - Trigger write raises the numbered interrupt
// - Only peripheral interrupts, never system exceptions
// - Unprivileged trigger writes ignored by default
// - User pend permit lets unprivileged writes trigger
// - Trigger bits 31:9 written zero, read undefined
// - Trigger register only on main core
`ifndef IPST_CFG_SVH
`define IPST_CFG_SVH

// Register offsets on the local port
`define IPST_PRIO_OFS      8'h00
`define IPST_TRIG_OFS      8'h04
`define IPST_STAT_OFS      8'h08

// Priority register fields
`define IPST_P1_MSB        7
`define IPST_P1_LSB        5
`define IPST_P2_MSB        15
`define IPST_P2_LSB        13
`define IPST_PRIO_RST      3'h0

// Trigger register field
`define IPST_ID_MSB        8
`define IPST_ID_LSB        0

// Status register fields
`define IPST_ST_ID_MSB     8
`define IPST_ST_ID_LSB     0
`define IPST_ST_REFUSED    16
`define IPST_ST_WVALID     17
`define IPST_ST_WID        18

// Reset values and default peripheral line count
`define IPST_ID_RST        9'h000
`define IPST_NUM_IRQ_DEF   64

`endif

// [logic/ipst_pkg.sv]
// Types shared by the priority/trigger block.
// Assumes the constants header is included by each user.
package ipst_pkg;
  typedef logic [8:0] ipst_id_t;    // Peripheral interrupt number
  typedef logic [2:0] ipst_prio_t;  // Zero is most urgent
  // Register select, one-hot
  typedef enum logic [3:0] {
    SEL_NONE = 4'b0001,
    SEL_PRIO = 4'b0010,
    SEL_TRIG = 4'b0100,
    SEL_STAT = 4'b1000
  } ipst_sel_e;
endpackage

// [logic/ipst_trig_if.sv]
// Carrier between the register front end and the trigger gate.
// Assumes both ends run on the core clock.
`timescale 1ns/1ps
`default_nettype none
interface ipst_trig_if (
  input wire logic clk,  // Core clock
  input wire logic rst   // Synchronous reset
);
  import ipst_pkg::*;
  logic     wr;      // Trigger register written
  logic     priv;    // Access is privileged
  logic     permit;  // User pend permit from core config
  ipst_id_t id;      // Requested number
  logic     accept;  // Write raises the interrupt
  logic     refuse;  // Write dropped
  modport ctrl (input clk, input rst, output wr, output priv, output permit,
                output id, input accept, input refuse);
  modport gate (input clk, input rst, input wr, input priv, input permit,
                input id, output accept, output refuse);
endinterface
`default_nettype wire

// [logic/ipst_trig_gate.sv]
// Privilege and range gate for software trigger writes.
// Assumes write, privilege and permit all arrive on the core clock.
`timescale 1ns/1ps
`default_nettype none
`include "ipst_cfg.svh"
module ipst_trig_gate #(
  parameter bit          MAIN_CORE = 1'b1,                // Register present
  parameter int unsigned NUM_IRQ   = `IPST_NUM_IRQ_DEF    // Peripheral lines
) (
  ipst_trig_if.gate t
);
  import ipst_pkg::*;
  logic allowed;  // Privilege check passed
  logic in_range; // Number names a peripheral line

  // Privileged always, unprivileged only with permit
  always_comb begin
    allowed  = t.priv || t.permit;
    in_range = 32'(t.id) < NUM_IRQ;
  end

  // Absent register on the small core never triggers
  assign t.accept = MAIN_CORE && t.wr && allowed && in_range;
  assign t.refuse = t.wr && !t.accept;

  no_small_core_a: assert property (@(posedge t.clk) disable iff (t.rst)
    !MAIN_CORE |-> !t.accept)
    else $error("trigger accepted on small core");
endmodule // ipst_trig_gate
`default_nettype wire

// [logic/ipst_prio_arb.sv]
// Fixed-level arbiter over the timer interrupt lines.
// Assumes requests are already pending and enabled, same clock domain.
`timescale 1ns/1ps
`default_nettype none
module ipst_prio_arb #(
  parameter int N  = 2,                       // Number of lines
  parameter int IW = (N > 1) ? $clog2(N) : 1  // Winner index width
) (
  input  wire logic               i_req [N],  // Pending and enabled
  input  wire ipst_pkg::ipst_prio_t i_prio [N], // Level per line
  output logic                    o_valid,    // Some line requests
  output logic [IW-1:0]           o_id        // Winning line
);
  import ipst_pkg::*;
  ipst_prio_t best;  // Lowest level seen so far

  // Strictly lower level wins; on a tie the lower index keeps it
  always_comb begin
    best    = '1;
    o_valid = 1'b0;
    o_id    = '0;
    for (int i = 0; i < N; i++) begin
      if (i_req[i] && (!o_valid || i_prio[i] < best)) begin
        o_valid = 1'b1;
        best    = i_prio[i];
        o_id    = IW'(i);
      end
    end
  end
endmodule // ipst_prio_arb
`default_nettype wire

// [logic/ipst_top.sv]
// Timer priority group register, software trigger register and status.
// Assumes pending/enable logic outside; all inputs on the core clock.
//
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "ipst_cfg.svh"
module ipst_top #(
  parameter bit          MAIN_CORE = 1'b1,              // Trigger present
  parameter int unsigned NUM_IRQ   = `IPST_NUM_IRQ_DEF  // Peripheral lines
) (
  input  wire logic               I_CLK,               // Core clock
  input  wire logic               I_RST,               // Sync reset, high
  input  wire logic [7:0]         I_ADDR,              // Register offset
  input  wire logic [31:0]        I_WDATA,             // Write data
  input  wire logic               I_WR,                // Write strobe
  input  wire logic               I_RD,                // Read strobe
  input  wire logic               I_PRIV,              // Access privileged
  input  wire logic               I_USER_PEND_PERMIT,  // From core config
  input  wire logic [1:0]         I_TIMER_REQ,         // Pending and enabled
  output logic [31:0]             O_RDATA,             // Read data
  output logic                    O_SET_PEND,          // Set-pending pulse
  output ipst_pkg::ipst_id_t      O_SET_PEND_NUM,      // Number to pend
  output ipst_pkg::ipst_prio_t    O_FIRST_TIMER_PRIO,  // First timer level
  output ipst_pkg::ipst_prio_t    O_SECOND_TIMER_PRIO, // Second timer level
  output logic                    O_WIN_VALID,         // A timer wins
  output logic                    O_WIN_ID             // Which timer wins
);
  import ipst_pkg::*;

  // Register state and next values
  ipst_prio_t p1_r, p1_nxt;          // First timer level
  ipst_prio_t p2_r, p2_nxt;          // Second timer level
  logic       pend_r, pend_nxt;      // Set-pending strobe
  ipst_id_t   num_r, num_nxt;        // Last accepted number
  logic       refused_r, refused_nxt; // Last trigger write dropped
  logic       wvalid_r, wvalid_nxt;  // Registered arbiter result
  logic       wid_r, wid_nxt;        // Registered winner
  logic [31:0] rdata_r, rdata_nxt;   // Read data, one cycle late

  // Decode and helper nets
  ipst_sel_e  sel;                   // Addressed register
  logic       arb_valid;             // Arbiter has a winner
  logic [0:0] arb_id;                // Arbiter winner index
  logic       req_a [2];             // Requests as array
  ipst_prio_t prio_a [2];            // Levels as array

  ipst_trig_if trig_if (
    .clk (I_CLK),
    .rst (I_RST)
  );

  // Address decode; small core has no trigger register
  always_comb begin
    case (I_ADDR)
      `IPST_PRIO_OFS: sel = SEL_PRIO;
      `IPST_TRIG_OFS: sel = MAIN_CORE ? SEL_TRIG : SEL_NONE;
      `IPST_STAT_OFS: sel = SEL_STAT;
      default:        sel = SEL_NONE;
    endcase
  end

  // Trigger write path; upper bits ignored, software keeps them zero
  assign trig_if.wr     = I_WR && (sel == SEL_TRIG);
  assign trig_if.priv   = I_PRIV;
  assign trig_if.permit = I_USER_PEND_PERMIT;
  assign trig_if.id     = I_WDATA[`IPST_ID_MSB:`IPST_ID_LSB];

  ipst_trig_gate #(
    .MAIN_CORE (MAIN_CORE),
    .NUM_IRQ   (NUM_IRQ)
  ) u_gate (
    .t (trig_if.gate)
  );

  // Arbiter inputs, first timer on index zero
  always_comb begin
    req_a[0]  = I_TIMER_REQ[0];
    req_a[1]  = I_TIMER_REQ[1];
    prio_a[0] = p1_r;
    prio_a[1] = p2_r;
  end

  ipst_prio_arb #(
    .N  (2),
    .IW (1)
  ) u_arb (
    .i_req   (req_a),
    .i_prio  (prio_a),
    .o_valid (arb_valid),
    .o_id    (arb_id)
  );

  // Next state of every register of the block
  always_comb begin
    p1_nxt      = p1_r;
    p2_nxt      = p2_r;
    rdata_nxt   = 32'h0000_0000;
    // Priority fields; other bits not stored and read zero
    if (I_WR && sel == SEL_PRIO) begin
      p1_nxt = I_WDATA[`IPST_P1_MSB:`IPST_P1_LSB];
      p2_nxt = I_WDATA[`IPST_P2_MSB:`IPST_P2_LSB];
    end
    // Accepted write pends the line like a set-pending write
    pend_nxt    = trig_if.accept;
    num_nxt     = trig_if.accept ? trig_if.id : num_r;
    // Hardware-only flag: last trigger verdict
    if (trig_if.refuse) begin
      refused_nxt = 1'b1;
    end else if (trig_if.accept) begin
      refused_nxt = 1'b0;
    end else begin
      refused_nxt = refused_r;
    end
    // Winner registered so outputs come from flops
    wvalid_nxt  = arb_valid;
    wid_nxt     = arb_id[0];
    // Read mux; data stands only in the cycle after the strobe
    if (I_RD) begin
      case (sel)
        SEL_PRIO: begin
          rdata_nxt[`IPST_P1_MSB:`IPST_P1_LSB] = p1_r;
          rdata_nxt[`IPST_P2_MSB:`IPST_P2_LSB] = p2_r;
        end
        SEL_STAT: begin
          rdata_nxt[`IPST_ST_ID_MSB:`IPST_ST_ID_LSB] = num_r;
          rdata_nxt[`IPST_ST_REFUSED]                = refused_r;
          rdata_nxt[`IPST_ST_WVALID]                 = wvalid_r;
          rdata_nxt[`IPST_ST_WID]                    = wid_r;
        end
        SEL_TRIG: rdata_nxt = 32'h0000_0000;
        SEL_NONE: rdata_nxt = 32'h0000_0000;
        default:  rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Register everything; reset values are constants
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      p1_r      <= `IPST_PRIO_RST;
      p2_r      <= `IPST_PRIO_RST;
      pend_r    <= 1'b0;
      num_r     <= `IPST_ID_RST;
      refused_r <= 1'b0;
      wvalid_r  <= 1'b0;
      wid_r     <= 1'b0;
      rdata_r   <= 32'h0000_0000;
    end else begin
      p1_r      <= p1_nxt;
      p2_r      <= p2_nxt;
      pend_r    <= pend_nxt;
      num_r     <= num_nxt;
      refused_r <= refused_nxt;
      wvalid_r  <= wvalid_nxt;
      wid_r     <= wid_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  // Outputs straight from flops
  assign O_RDATA             = rdata_r;
  assign O_SET_PEND          = pend_r;
  assign O_SET_PEND_NUM      = num_r;
  assign O_FIRST_TIMER_PRIO  = p1_r;
  assign O_SECOND_TIMER_PRIO = p2_r;
  assign O_WIN_VALID         = wvalid_r;
  assign O_WIN_ID            = wid_r;

  // Checks on the register port and trigger path
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  // Named steps of a priority write and a trigger write
  sequence prio_wr_s;
    I_WR && I_ADDR == `IPST_PRIO_OFS;
  endsequence

  sequence trig_wr_s;
    MAIN_CORE && I_WR && I_ADDR == `IPST_TRIG_OFS;
  endsequence

  sequence trig_ok_s;
    trig_wr_s ##0 32'(I_WDATA[8:0]) < NUM_IRQ;
  endsequence

  // Written level shows on the first timer output in the cycle after the write
  first_prio_store_a: assert property (
    prio_wr_s ##1 !(I_WR && I_ADDR == `IPST_PRIO_OFS)
      |-> O_FIRST_TIMER_PRIO == $past(I_WDATA[7:5]))
    else $error("first timer level not stored");

  // Second timer field tracks bits 15:13 on readback
  second_prio_read_a: assert property (
    I_RD && I_ADDR == `IPST_PRIO_OFS
      |=> O_RDATA[15:13] == $past(O_SECOND_TIMER_PRIO) &&
          O_RDATA[12:0] == {$past(O_FIRST_TIMER_PRIO), 5'h00} &&
          O_RDATA[31:16] == 16'h0000)
    else $error("priority readback wrong");

  // Lower level beats higher when both timers request
  level_win_a: assert property (
    I_TIMER_REQ == 2'b11 && O_SECOND_TIMER_PRIO < O_FIRST_TIMER_PRIO
      |=> O_WIN_VALID && O_WIN_ID)
    else $error("lower level did not win");

  // Privileged write in range pends that number one cycle later
  trig_pend_a: assert property (
    trig_ok_s ##0 I_PRIV
      |=> O_SET_PEND && O_SET_PEND_NUM == $past(I_WDATA[8:0]))
    else $error("trigger write did not pend");

  // Numbers past the peripheral lines never pend
  range_block_a: assert property (
    trig_wr_s ##0 32'(I_WDATA[8:0]) >= NUM_IRQ |=> !O_SET_PEND)
    else $error("out of range number pended");

  // Unprivileged without permit neither pends nor moves the pended number
  unpriv_block_a: assert property (
    trig_wr_s ##0 !I_PRIV && !I_USER_PEND_PERMIT
      |=> !O_SET_PEND && O_SET_PEND_NUM == $past(O_SET_PEND_NUM))
    else $error("unprivileged trigger took effect");

  // Permit opens the path to unprivileged writes
  user_permit_a: assert property (
    trig_ok_s ##0 !I_PRIV && I_USER_PEND_PERMIT |=> O_SET_PEND)
    else $error("permitted user trigger dropped");

  // Trigger readback is all zero in the cycle after the strobe and in the next
  trig_read_a: assert property (
    I_RD && I_ADDR == `IPST_TRIG_OFS ##1 !I_RD
      |-> O_RDATA == 32'h0000_0000 ##1 O_RDATA == 32'h0000_0000)
    else $error("trigger readback not zero");

  // Pend is a single-cycle strobe without a fresh write
  pend_pulse_a: assert property (
    O_SET_PEND && !trig_if.accept |=> !O_SET_PEND)
    else $error("set-pending strobe stretched");

  // A tie between equal levels goes to the first timer
  tie_first_a: assert property (
    I_TIMER_REQ == 2'b11 && O_SECOND_TIMER_PRIO == O_FIRST_TIMER_PRIO
      |=> O_WIN_VALID && !O_WIN_ID)
    else $error("tie not given to first timer");

  // No request, no winner on the next cycle
  idle_win_a: assert property (
    I_TIMER_REQ == 2'b00 |=> !O_WIN_VALID)
    else $error("winner shown without request");

  // Read data is zero unless a read strobe came a cycle before
  rdata_idle_a: assert property (
    !I_RD |=> O_RDATA == 32'h0000_0000)
    else $error("read data without read strobe");

  // No pend pulse unless the trigger offset was written
  pend_cause_a: assert property (
    !(MAIN_CORE && I_WR && I_ADDR == `IPST_TRIG_OFS) |=> !O_SET_PEND)
    else $error("pend pulse without trigger write");

  // Pended number holds between accepted writes
  num_hold_a: assert property (
    !trig_if.accept |=> $stable(O_SET_PEND_NUM))
    else $error("pended number moved without trigger");

  // A dropped write raises the refusal flag in status
  refuse_flag_a: assert property (
    trig_if.refuse |=> refused_r)
    else $error("refusal not recorded");

  // Small core: the trigger offset is dead, nothing pends
  small_dead_a: assert property (
    !MAIN_CORE && I_WR && I_ADDR == `IPST_TRIG_OFS |=> !O_SET_PEND)
    else $error("small core pended a trigger");

  // Levels only move on a priority write
  // Guards against a stray decode hitting the level flops
  prio_hold_a: assert property (
    !(I_WR && I_ADDR == `IPST_PRIO_OFS)
      |=> $stable(O_FIRST_TIMER_PRIO) && $stable(O_SECOND_TIMER_PRIO))
    else $error("timer level changed without write");

  // Read of an unmapped offset returns zero
  unmapped_read_a: assert property (
    I_RD && I_ADDR != `IPST_PRIO_OFS && I_ADDR != `IPST_STAT_OFS
      |=> O_RDATA == 32'h0000_0000)
    else $error("unmapped read not zero");

  // Note: these checks assume strobes are never both high at once;
  // the port does not arbitrate a read against a write in one cycle.

endmodule // ipst_top
`default_nettype wire

// [verification/ipst_tb.sv]
// Self-checking bench for the timer priority group and software trigger block.
// Assumes the package and the constants header are compiled and on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "ipst_cfg.svh"
module testbench;
  import ipst_pkg::*;
  localparam int unsigned NIRQ = 64;  // Peripheral line count under test
  logic        i_clk;                 // Core clock
  logic        i_rst;                 // Sync reset, high
  logic [7:0]  i_addr;                // Register offset
  logic [31:0] i_wdata;               // Write data
  logic        i_wr;                  // Write strobe
  logic        i_rd;                  // Read strobe
  logic        i_priv;                // Privileged access
  logic        i_permit;              // User pend permit level
  logic [1:0]  i_req;                 // Timer requests
  logic [31:0] o_rdata;               // Main core read data
  logic [31:0] s_rdata;               // Small core read data
  logic        o_pend;                // Main core set-pending pulse
  logic        s_pend;                // Small core set-pending pulse
  ipst_id_t    o_num;                 // Number to pend
  ipst_prio_t  o_p1;                  // First timer level
  ipst_prio_t  o_p2;                  // Second timer level
  logic        o_wv;                  // A timer wins
  logic        o_wid;                 // Winning timer
  int          n_errors;              // Mismatches seen
  int          cmp_count;             // Comparisons made
  ipst_id_t    last;                  // Last accepted number
  logic [31:0] d;                     // Read result

  // Main core instance, trigger register present
  ipst_top #(.MAIN_CORE(1'b1), .NUM_IRQ(NIRQ)) DUT (
    .I_CLK(i_clk), .I_RST(i_rst), .I_ADDR(i_addr), .I_WDATA(i_wdata), .I_WR(i_wr),
    .I_RD(i_rd), .I_PRIV(i_priv), .I_USER_PEND_PERMIT(i_permit), .I_TIMER_REQ(i_req),
    .O_RDATA(o_rdata), .O_SET_PEND(o_pend), .O_SET_PEND_NUM(o_num),
    .O_FIRST_TIMER_PRIO(o_p1), .O_SECOND_TIMER_PRIO(o_p2),
    .O_WIN_VALID(o_wv), .O_WIN_ID(o_wid));

  // Small core instance shares the stimulus, trigger register absent
  ipst_top #(.MAIN_CORE(1'b0), .NUM_IRQ(NIRQ)) DUT2 (
    .I_CLK(i_clk), .I_RST(i_rst), .I_ADDR(i_addr), .I_WDATA(i_wdata), .I_WR(i_wr),
    .I_RD(i_rd), .I_PRIV(i_priv), .I_USER_PEND_PERMIT(i_permit), .I_TIMER_REQ(i_req),
    .O_RDATA(s_rdata), .O_SET_PEND(s_pend), .O_SET_PEND_NUM(),
    .O_FIRST_TIMER_PRIO(), .O_SECOND_TIMER_PRIO(), .O_WIN_VALID(), .O_WIN_ID());

  // Free-running core clock, 100 MHz
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // Counts one comparison, reports a difference at once
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One-cycle write; returns in the cycle where its effect shows
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic p);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= v;
    i_priv  <= p;
    @(posedge i_clk);
    i_wr    <= 1'b0;
    #1;
  endtask

  // One-cycle read; data taken in the single cycle it stands
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    #1;
    v = o_rdata;
  endtask

  // Trigger write with expected outcome; upper bits always written zero
  task automatic trig(input logic [8:0] n, input logic p, input logic pm, input logic acc);
    @(posedge i_clk);
    i_permit <= pm;
    wr(`IPST_TRIG_OFS, {23'h00_0000, n}, p);
    chk(o_pend, acc);
    if (acc) last = n;
    chk(o_num, last);
    rd(`IPST_STAT_OFS, d);
    chk(d[16], !acc);
    chk(d[8:0], last);
    chk(o_pend, 1'b0);
  endtask

  // Sets both levels, raises requests, checks the winner a cycle later
  task automatic arb(input logic [2:0] a, input logic [2:0] b, input logic [1:0] r,
                     input logic ev, input logic eid);
    wr(`IPST_PRIO_OFS, {16'h0000, b, 5'h00, a, 5'h00}, 1'b1);
    @(posedge i_clk);
    i_req <= r;
    @(posedge i_clk);
    #1;
    chk(o_wv, ev);
    if (ev) chk(o_wid, eid);
  endtask

  // Verdict and end of run, the single exit point
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Hang guard: a run this long counts as a failure
  initial begin
    repeat (20000) @(posedge i_clk);
    n_errors++;
    close_out();
  end

  // Main sequence
  initial begin
    n_errors = 0;
    cmp_count = 0;
    last = 9'h000;
    i_rst = 1'b1;
    i_addr = 8'h00;
    i_wdata = 32'h0000_0000;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_priv = 1'b0;
    i_permit = 1'b0;
    i_req = 2'b00;
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(`IPST_PRIO_OFS, d);
    chk(d, 32'h0000_0000);
    // Unused and reserved bits never stored
    wr(`IPST_PRIO_OFS, 32'hFFFF_FFFF, 1'b1);
    chk({o_p2, o_p1}, 6'h3F);
    rd(`IPST_PRIO_OFS, d);
    chk(d, 32'h0000_E0E0);
    wr(`IPST_PRIO_OFS, 32'h0000_A0E0, 1'b1);
    chk(o_p1, 3'h7);
    chk(o_p2, 3'h5);
    rd(`IPST_PRIO_OFS, d);
    chk(d, 32'h0000_A0E0);
    rd(8'h0C, d);
    chk(d, 32'h0000_0000);
    // Every level against its mirror, then a tie and single requests
    for (int p = 0; p < 8; p++) arb(p[2:0], 3'h7 - p[2:0], 2'b11, 1'b1, (7 - p) < p);
    arb(3'h3, 3'h3, 2'b11, 1'b1, 1'b0);
    arb(3'h0, 3'h7, 2'b10, 1'b1, 1'b1);
    arb(3'h7, 3'h0, 2'b01, 1'b1, 1'b0);
    arb(3'h0, 3'h0, 2'b00, 1'b0, 1'b0);
    // Privilege and permit, all four combinations
    for (int k = 0; k < 4; k++) trig(9'd20 + k[8:0], k[0], k[1], k != 0);
    // Range boundary: last peripheral line and beyond
    trig(NIRQ[8:0] - 9'd1, 1'b1, 1'b0, 1'b1);
    trig(NIRQ[8:0], 1'b1, 1'b0, 1'b0);
    trig(9'h1FF, 1'b1, 1'b1, 1'b0);
    rd(`IPST_TRIG_OFS, d);
    chk(d, 32'h0000_0000);
    // Back-to-back triggers give back-to-back pulses
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= `IPST_TRIG_OFS;
    i_wdata <= 32'h0000_000A;
    i_priv <= 1'b1;
    @(posedge i_clk);
    i_wdata <= 32'h0000_000B;
    #1;
    chk({o_pend, o_num}, {1'b1, 9'h00A});
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
    chk({o_pend, o_num}, {1'b1, 9'h00B});
    chk(s_pend, 1'b0);
    rd(`IPST_TRIG_OFS, d);
    chk(s_rdata, 32'h0000_0000);
    // Reset in mid-run clears stored levels that are not zero
    wr(`IPST_PRIO_OFS, 32'h0000_A0E0, 1'b1);
    chk({o_p2, o_p1}, 6'h2F);
    @(posedge i_clk);
    i_rst <= 1'b1;
    @(posedge i_clk);
    i_rst <= 1'b0;
    #1;
    chk({o_p2, o_p1, o_pend}, 7'h00);
    rd(`IPST_PRIO_OFS, d);
    chk(d, 32'h0000_0000);
    close_out();
  end
endmodule // testbench
`default_nettype wire
